// >>> serial_port_params.svh
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH

// ----------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------
`define IDX_CONTROL      8'h98
`define IDX_DATA         8'h99
`define IDX_OWN_ADDR     8'ha9
`define IDX_ADDR_MASK    8'hb9
`define IDX_CONFIG       8'hc0
`define IDX_IRQ_STATUS   8'hc1
`define IDX_IRQ_MASK     8'hc2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTL_FE_MODEHI    7
`define CTL_MODELO       6
`define CTL_MPEN         5
`define CTL_RXEN         4
`define CTL_TX9          3
`define CTL_RX9          2
`define CTL_TXDONE       1
`define CTL_RXDONE       0
`define CFG_VIEW         0
`define CFG_X2           1
`define CFG_DIV_LO       16
`define IRQ_TX           0
`define IRQ_RX           1
`define IRQ_FE           2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_BYTE         8'h00
`define RST_DIV          16'h0010
`define RST_IRQ          3'h0

// ----------------------------------------------------------------
// mode codes and bus answers
// ----------------------------------------------------------------
`define MODE_SHIFT       2'h0
`define MODE_UART8       2'h1
`define MODE_UART9       2'h2
`define MODE_UART9V      2'h3
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// ----------------------------------------------------------------
// timing counts in mclk cycles per bit
// ----------------------------------------------------------------
`define DIV_MODE0        16'h000c
`define DIV_MODE0_X2     16'h0006
`define DIV_MODE2        16'h0040
`define DIV_MODE2_X2     16'h0020

`endif

// >>> serial_port_pkg.sv
package serial_port_pkg;

	typedef enum logic [2:0] {
		TX_IDLE, TX_SHIFT, TX_START, TX_DATA, TX_NINTH, TX_STOP
	} tx_state_e;

	typedef enum logic [2:0] {
		RX_IDLE, RX_SHIFT, RX_START, RX_DATA, RX_NINTH, RX_STOP
	} rx_state_e;

endpackage

// >>> bit_timer.sv
`timescale 1ns/1ps

module bit_timer (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// control
	input  wire logic        run,
	input  wire logic        halfFirst,
	input  wire logic [15:0] period,
	// bit enable
	output logic             tick
);

	logic [15:0] count;
	logic [15:0] next_count;
	logic        next_tick;

	// ----------------------------------------------------------------
	// countdown, reloads so the rate holds across ticks
	// ----------------------------------------------------------------
	always_comb begin
		next_count = count;
		next_tick = 1'b0;
		if (!run) begin
			next_count = halfFirst ? {1'b0, period[15:1]} : period;
		end else if (count <= 16'h0001) begin
			next_tick = 1'b1;
			next_count = period;
		end else begin
			next_count = count - 16'h0001;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			count <= 16'h0000;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end

endmodule // bit_timer

// >>> serial_port_uart_regs.sv
// Notes on behaviour
// - mode 0 shifts at mclk/12 (/6), mode 1 is an 8-bit uart, mode 2 a 9-bit uart at /64 (/32).
// - address filtering acts only in modes 2 and 3 and only while multiprocessor enable is set.
// - frames are received only while receive enable is set.
// - in 9-bit modes the ninth transmit bit goes out as the ninth data bit.
// - in 9-bit modes the ninth received bit is loaded into the ninth receive bit.
// - tx done sets after bit eight in mode 0, else as the stop bit starts; software clears it.
// - receive done is set at the end of the eighth bit time in mode 0, and software clears it.
// - an 8-bit mask register whose zero bits mark don't-care address positions.
// - an 8-bit writable own-address register holds the node address.
// - two 8-bit data buffers share one register index: writes load sent data, reads return received data.
// - control bit 7 shows the framing error flag if view select is set, else the high mode bit.
// - the framing error flag stays set until software or reset clears it.
// - given address is own address with mask zeros as don't-care; rx done only on a match.
// - a broadcast address, own address or mask with zeros as don't-care, is also accepted.
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "serial_port_params.svh"

module serial_port_uart_regs (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// axi4-lite write
	input  wire logic [9:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read
	input  wire logic [9:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// serial pins
	output logic             txd,
	input  wire logic        rxdIn,
	output logic             rxdOut,
	output logic             rxdOeN,
	// interrupt
	output logic             irq
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic        awHeld, wHeld, next_awHeld, next_wHeld, next_awready, next_wready;
	logic [9:0]  awAddrQ, next_awAddrQ;
	logic [31:0] wDataQ, next_wDataQ, next_rdata;
	logic [3:0]  wStrbQ, next_wStrbQ;
	logic        next_bvalid, next_arready, next_rvalid;
	logic [1:0]  next_bresp, next_rresp;
	logic [1:0]  mode, next_mode;
	logic        mpEnable, rxEnable, ninthTx, ninthRx, txDone, rxDone, framingError;
	logic        next_mpEnable, next_rxEnable, next_ninthTx, next_ninthRx;
	logic        next_txDone, next_rxDone, next_framingError;
	logic [7:0]  txByte, rxHold, ownAddr, addrMask;
	logic [7:0]  next_txByte, next_rxHold, next_ownAddr, next_addrMask, ctlView;
	logic        viewSelect, doubleSpeed, next_viewSelect, next_doubleSpeed;
	logic [15:0] baudDiv, next_baudDiv, bitPeriod;
	logic [2:0]  irqStatus, irqMask, next_irqStatus, next_irqMask, irqEvents;
	logic        txStart, next_txStart, next_irq, doWrite;
	logic [7:0]  wIdx;
	serial_port_pkg::tx_state_e txState, next_txState;
	serial_port_pkg::rx_state_e rxState, next_rxState;
	logic [8:0]  txShift, next_txShift;
	logic [2:0]  txCount, next_txCount, rxCount, next_rxCount;
	logic        txPhase, next_txPhase, rxPhase, next_rxPhase, txTick, rxTick;
	logic        txEvt, rxEvt, feEvt, nineBit;
	logic [7:0]  rxData, next_rxData;
	logic        rxNinth, next_rxNinth, givenHit, bcastHit;
	logic        sync1, sync2, sync3, rxdFilt, next_rxdFilt;
	logic        next_txd, next_rxdOut, next_rxdOeN;

	// ----------------------------------------------------------------
	// bit rate per mode
	// ----------------------------------------------------------------
	assign nineBit = mode[1];
	always_comb begin
		case (mode)
			`MODE_SHIFT: bitPeriod = doubleSpeed ? `DIV_MODE0_X2 : `DIV_MODE0;
			`MODE_UART9: bitPeriod = doubleSpeed ? `DIV_MODE2_X2 : `DIV_MODE2;
			default: bitPeriod = baudDiv;
		endcase
	end

	// mode 0 runs the timer at half bit so the shift clock has two phases
	bit_timer txTimer (
		.mclk      (mclk),
		.rst       (rst),
		.run       (txState != serial_port_pkg::TX_IDLE),
		.halfFirst (1'b0),
		.period    ((mode == `MODE_SHIFT) ? {1'b0, bitPeriod[15:1]} : bitPeriod),
		.tick      (txTick)
	);

	bit_timer rxTimer (
		.mclk      (mclk),
		.rst       (rst),
		.run       (rxState != serial_port_pkg::RX_IDLE),
		.halfFirst (mode != `MODE_SHIFT),
		.period    ((mode == `MODE_SHIFT) ? {1'b0, bitPeriod[15:1]} : bitPeriod),
		.tick      (rxTick)
	);

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	always_comb begin
		next_txState = txState;
		next_txShift = txShift;
		next_txCount = txCount;
		next_txPhase = txPhase;
		txEvt = 1'b0;
		unique case (txState)
			serial_port_pkg::TX_IDLE: begin
				next_txCount = 3'h0;
				next_txPhase = 1'b0;
				if (txStart) begin
					next_txShift = {ninthTx, txByte};
					next_txState = (mode == `MODE_SHIFT) ? serial_port_pkg::TX_SHIFT
						: serial_port_pkg::TX_START;
				end
			end
			serial_port_pkg::TX_SHIFT: if (txTick) begin
				next_txPhase = !txPhase;
				if (txPhase) begin
					next_txShift = {1'b0, txShift[8:1]};
					next_txCount = txCount + 3'h1;
					if (txCount == 3'h7) begin
						txEvt = 1'b1;
						next_txState = serial_port_pkg::TX_IDLE;
					end
				end
			end
			serial_port_pkg::TX_START: if (txTick) begin
				next_txState = serial_port_pkg::TX_DATA;
			end
			serial_port_pkg::TX_DATA: if (txTick) begin
				next_txShift = {1'b0, txShift[8:1]};
				next_txCount = txCount + 3'h1;
				if (txCount == 3'h7) begin
					next_txState = nineBit ? serial_port_pkg::TX_NINTH
						: serial_port_pkg::TX_STOP;
					txEvt = !nineBit;
				end
			end
			serial_port_pkg::TX_NINTH: if (txTick) begin
				txEvt = 1'b1;
				next_txState = serial_port_pkg::TX_STOP;
			end
			serial_port_pkg::TX_STOP: if (txTick) begin
				next_txState = serial_port_pkg::TX_IDLE;
			end
			default: next_txState = serial_port_pkg::TX_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			txState <= serial_port_pkg::TX_IDLE;
			txShift <= 9'h000;
			txCount <= 3'h0;
			txPhase <= 1'b0;
		end else begin
			txState <= next_txState;
			txShift <= next_txShift;
			txCount <= next_txCount;
			txPhase <= next_txPhase;
		end
	end

	// ----------------------------------------------------------------
	// receiver and address recognition
	// ----------------------------------------------------------------
	assign givenHit = ((rxData ^ ownAddr) & addrMask) == 8'h00;
	assign bcastHit = ((rxData ^ (ownAddr | addrMask)) & (ownAddr | addrMask)) == 8'h00;

	always_comb begin
		next_rxState = rxState;
		next_rxData = rxData;
		next_rxNinth = rxNinth;
		next_rxCount = rxCount;
		next_rxPhase = rxPhase;
		rxEvt = 1'b0;
		feEvt = 1'b0;
		unique case (rxState)
			serial_port_pkg::RX_IDLE: begin
				next_rxCount = 3'h0;
				next_rxPhase = 1'b0;
				// mode 0 waits for software to free the holding register
				if (rxEnable && mode == `MODE_SHIFT && !rxDone
					&& txState == serial_port_pkg::TX_IDLE) begin
					next_rxState = serial_port_pkg::RX_SHIFT;
				end else if (rxEnable && mode != `MODE_SHIFT && !rxdFilt) begin
					next_rxState = serial_port_pkg::RX_START;
				end
			end
			serial_port_pkg::RX_SHIFT: if (rxTick) begin
				next_rxPhase = !rxPhase;
				if (!rxPhase) begin
					next_rxData = {rxdFilt, rxData[7:1]};
				end else begin
					next_rxCount = rxCount + 3'h1;
					if (rxCount == 3'h7) begin
						rxEvt = 1'b1;
						next_rxState = serial_port_pkg::RX_IDLE;
					end
				end
			end
			serial_port_pkg::RX_START: if (rxTick) begin
				// a start bit that is gone at mid-bit was a glitch
				next_rxState = rxdFilt ? serial_port_pkg::RX_IDLE : serial_port_pkg::RX_DATA;
			end
			serial_port_pkg::RX_DATA: if (rxTick) begin
				next_rxData = {rxdFilt, rxData[7:1]};
				next_rxCount = rxCount + 3'h1;
				if (rxCount == 3'h7) begin
					next_rxState = nineBit ? serial_port_pkg::RX_NINTH
						: serial_port_pkg::RX_STOP;
				end
			end
			serial_port_pkg::RX_NINTH: if (rxTick) begin
				next_rxNinth = rxdFilt;
				next_rxState = serial_port_pkg::RX_STOP;
			end
			serial_port_pkg::RX_STOP: if (rxTick) begin
				next_rxState = serial_port_pkg::RX_IDLE;
				feEvt = !rxdFilt;
				if (!nineBit) begin
					next_rxNinth = rxdFilt;
				end
				if (mpEnable && nineBit) begin
					rxEvt = rxNinth && (givenHit || bcastHit);
				end else begin
					rxEvt = 1'b1;
				end
			end
			default: next_rxState = serial_port_pkg::RX_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rxState <= serial_port_pkg::RX_IDLE;
			rxData <= `RST_BYTE;
			rxNinth <= 1'b0;
			rxCount <= 3'h0;
			rxPhase <= 1'b0;
		end else begin
			rxState <= next_rxState;
			rxData <= next_rxData;
			rxNinth <= next_rxNinth;
			rxCount <= next_rxCount;
			rxPhase <= next_rxPhase;
		end
	end

	// ----------------------------------------------------------------
	// pins: three stage input filter and registered drivers
	// ----------------------------------------------------------------
	always_comb begin
		next_rxdFilt = (sync2 == sync3) ? sync3 : rxdFilt;
		next_txd = 1'b1;
		next_rxdOut = 1'b1;
		next_rxdOeN = 1'b1;
		if (txState == serial_port_pkg::TX_SHIFT) begin
			next_txd = next_txPhase || next_txState == serial_port_pkg::TX_IDLE;
			next_rxdOut = next_txShift[0];
			next_rxdOeN = 1'b0;
		end else if (rxState == serial_port_pkg::RX_SHIFT) begin
			next_txd = next_rxPhase || next_rxState == serial_port_pkg::RX_IDLE;
		end else if (next_txState == serial_port_pkg::TX_START) begin
			next_txd = 1'b0;
		end else if (next_txState == serial_port_pkg::TX_DATA
			|| next_txState == serial_port_pkg::TX_NINTH) begin
			next_txd = next_txShift[0];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
			sync3 <= 1'b1;
			rxdFilt <= 1'b1;
			txd <= 1'b1;
			rxdOut <= 1'b1;
			rxdOeN <= 1'b1;
		end else begin
			sync1 <= rxdIn;
			sync2 <= sync1;
			sync3 <= sync2;
			rxdFilt <= next_rxdFilt;
			txd <= next_txd;
			rxdOut <= next_rxdOut;
			rxdOeN <= next_rxdOeN;
		end
	end

	// ----------------------------------------------------------------
	// bus slave and register file
	// ----------------------------------------------------------------
	assign wIdx = awAddrQ[9:2];
	assign doWrite = awHeld && wHeld && !bvalid;
	assign irqEvents = {feEvt, rxEvt, txEvt};
	assign ctlView = {viewSelect ? framingError : mode[1], mode[0], mpEnable, rxEnable,
		ninthTx, ninthRx, txDone, rxDone};

	always_comb begin
		next_awHeld = awHeld || (awvalid && awready);
		next_wHeld = wHeld || (wvalid && wready);
		next_awAddrQ = (awvalid && awready) ? awaddr : awAddrQ;
		next_wDataQ = (wvalid && wready) ? wdata : wDataQ;
		next_wStrbQ = (wvalid && wready) ? wstrb : wStrbQ;
		next_bvalid = bvalid && !bready;
		next_bresp = bresp;
		next_rvalid = rvalid && !rready;
		next_rdata = rdata;
		next_rresp = rresp;
		next_mode = mode;
		next_mpEnable = mpEnable;
		next_rxEnable = rxEnable;
		next_ninthTx = ninthTx;
		next_ninthRx = ninthRx;
		next_txDone = txDone;
		next_rxDone = rxDone;
		next_framingError = framingError;
		next_txByte = txByte;
		next_rxHold = rxHold;
		next_ownAddr = ownAddr;
		next_addrMask = addrMask;
		next_viewSelect = viewSelect;
		next_doubleSpeed = doubleSpeed;
		next_baudDiv = baudDiv;
		next_irqStatus = irqStatus;
		next_irqMask = irqMask;
		next_txStart = 1'b0;
		if (doWrite) begin
			next_awHeld = 1'b0;
			next_wHeld = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = `RESP_OKAY;
			unique case (wIdx)
				`IDX_CONTROL: if (wStrbQ[0]) begin
					if (viewSelect) begin
						next_framingError = framingError && wDataQ[`CTL_FE_MODEHI];
					end else begin
						next_mode[1] = wDataQ[`CTL_FE_MODEHI];
					end
					next_mode[0] = wDataQ[`CTL_MODELO];
					next_mpEnable = wDataQ[`CTL_MPEN];
					next_rxEnable = wDataQ[`CTL_RXEN];
					next_ninthTx = wDataQ[`CTL_TX9];
					next_ninthRx = wDataQ[`CTL_RX9];
					next_txDone = wDataQ[`CTL_TXDONE];
					next_rxDone = wDataQ[`CTL_RXDONE];
				end
				`IDX_DATA: if (wStrbQ[0]) begin
					next_txByte = wDataQ[7:0];
					next_txStart = txState == serial_port_pkg::TX_IDLE;
				end
				`IDX_OWN_ADDR: if (wStrbQ[0]) next_ownAddr = wDataQ[7:0];
				`IDX_ADDR_MASK: if (wStrbQ[0]) next_addrMask = wDataQ[7:0];
				`IDX_CONFIG: begin
					if (wStrbQ[0]) next_viewSelect = wDataQ[`CFG_VIEW];
					if (wStrbQ[0]) next_doubleSpeed = wDataQ[`CFG_X2];
					if (wStrbQ[2]) next_baudDiv[7:0] = wDataQ[`CFG_DIV_LO +: 8];
					if (wStrbQ[3]) next_baudDiv[15:8] = wDataQ[`CFG_DIV_LO + 8 +: 8];
				end
				`IDX_IRQ_STATUS: if (wStrbQ[0]) next_irqStatus = irqStatus & ~wDataQ[2:0];
				`IDX_IRQ_MASK: if (wStrbQ[0]) next_irqMask = wDataQ[2:0];
				default: next_bresp = `RESP_SLVERR;
			endcase
		end
		// hardware events win over a clear in the same cycle
		if (txEvt) next_txDone = 1'b1;
		if (rxEvt) begin
			next_rxDone = 1'b1;
			next_rxHold = rxData;
			next_ninthRx = next_rxNinth;
		end
		if (feEvt) next_framingError = 1'b1;
		next_irqStatus = next_irqStatus | irqEvents;
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp = `RESP_OKAY;
			next_rdata = 32'h0000_0000;
			unique case (araddr[9:2])
				`IDX_CONTROL: next_rdata[7:0] = ctlView;
				`IDX_DATA: next_rdata[7:0] = rxHold;
				`IDX_OWN_ADDR: next_rdata[7:0] = ownAddr;
				`IDX_ADDR_MASK: next_rdata[7:0] = addrMask;
				`IDX_CONFIG: next_rdata = {baudDiv, 14'h0000, doubleSpeed, viewSelect};
				`IDX_IRQ_STATUS: next_rdata[2:0] = irqStatus;
				`IDX_IRQ_MASK: next_rdata[2:0] = irqMask;
				default: next_rresp = `RESP_SLVERR;
			endcase
		end
		next_awready = !next_awHeld && !next_bvalid;
		next_wready = !next_wHeld && !next_bvalid;
		next_arready = !next_rvalid;
		next_irq = |(next_irqStatus & next_irqMask);
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			awAddrQ <= 10'h000;
			wDataQ <= 32'h0000_0000;
			wStrbQ <= 4'h0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= `RESP_OKAY;
			mode <= `MODE_SHIFT;
			{mpEnable, rxEnable, ninthTx, ninthRx} <= 4'h0;
			{txDone, rxDone, framingError} <= 3'h0;
			txByte <= `RST_BYTE;
			rxHold <= `RST_BYTE;
			ownAddr <= `RST_BYTE;
			addrMask <= `RST_BYTE;
			viewSelect <= 1'b0;
			doubleSpeed <= 1'b0;
			baudDiv <= `RST_DIV;
			irqStatus <= `RST_IRQ;
			irqMask <= `RST_IRQ;
			txStart <= 1'b0;
			irq <= 1'b0;
		end else begin
			awHeld <= next_awHeld;
			wHeld <= next_wHeld;
			awAddrQ <= next_awAddrQ;
			wDataQ <= next_wDataQ;
			wStrbQ <= next_wStrbQ;
			awready <= next_awready;
			wready <= next_wready;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			arready <= next_arready;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			mode <= next_mode;
			{mpEnable, rxEnable, ninthTx, ninthRx} <=
				{next_mpEnable, next_rxEnable, next_ninthTx, next_ninthRx};
			{txDone, rxDone, framingError} <= {next_txDone, next_rxDone, next_framingError};
			txByte <= next_txByte;
			rxHold <= next_rxHold;
			ownAddr <= next_ownAddr;
			addrMask <= next_addrMask;
			viewSelect <= next_viewSelect;
			doubleSpeed <= next_doubleSpeed;
			baudDiv <= next_baudDiv;
			irqStatus <= next_irqStatus;
			irqMask <= next_irqMask;
			txStart <= next_txStart;
			irq <= next_irq;
		end
	end

endmodule // serial_port_uart_regs

// >>> serial_port_uart_regs_assertions.sv
`timescale 1ns/1ps
// ------------------------------
// bus and line checks
// ------------------------------
module serial_port_uart_regs_assertions (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// bus
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic [1:0]  bresp,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	// line
	input wire logic        txd
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_wtake;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_back;
		!bvalid ##[0:1] (awready && wready);
	endsequence
	a_b_latency: assert property (s_wtake |-> ##2 bvalid)
		else $error("write answer late");
	a_aw_drop: assert property (s_wtake |=> !awready && !wready)
		else $error("ready kept after take");
	a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	a_ready_back: assert property (bvalid && bready |=> s_back)
		else $error("write ready not back");
	a_r_latency: assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data moved");
	a_r_release: assert property (rvalid && rready |=> !rvalid)
		else $error("read answer kept");
	// a start bit or shift half is never shorter than two cycles
	a_txd_start: assert property ($fell(txd) |-> !txd [*2])
		else $error("short low on txd");
endmodule // serial_port_uart_regs_assertions

bind serial_port_uart_regs serial_port_uart_regs_assertions chk (.mclk(mclk), .rst(rst),
	.awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
	.arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .txd(txd));

// >>> serial_node_model.sv
`timescale 1ns/1ps
// ------------------------------
// remote node on the line
// ------------------------------
module serial_node_model (
	// clock
	input  wire logic mclk,
	// line
	input  wire logic txd,
	output logic      rxLine
);
	int         per = 16;
	int         nb  = 8;
	logic [9:0] cap = '0;
	logic [9:0] got[$];
	initial rxLine = 1'b1;
	// line returns to its pull-up level after each frame
	task automatic sendFrame(input logic [8:0] d, input logic stopBit);
		for (int i = -1; i <= nb; i++) begin
			rxLine <= (i < 0) ? 1'b0 : (i == nb) ? stopBit : d[i];
			repeat (per) @(posedge mclk);
		end
		rxLine <= 1'b1;
	endtask
	always begin
		@(negedge txd);
		repeat (per / 2) @(posedge mclk);
		if (!txd) begin
			for (int i = 0; i <= nb; i++) begin
				repeat (per) @(posedge mclk);
				cap[i] = txd;
			end
			got.push_back(cap);
		end
	end
endmodule // serial_node_model

// >>> serial_port_uart_regs_tb.sv
`timescale 1ns/1ps
`include "serial_port_params.svh"
module serial_port_uart_regs_tb;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [9:0]  awaddr = '0;
	logic [9:0]  araddr = '0;
	logic [31:0] wdata = '0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, txd, rxdOut, rxdOeN, irq, nodeLine;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rv;
	logic [7:0]  own, mask, b, sh;
	logic [7:0]  adr[4];
	logic [7:0]  regs[7] = '{`IDX_CONTROL, `IDX_DATA, `IDX_OWN_ADDR, `IDX_ADDR_MASK,
		`IDX_CONFIG, `IDX_IRQ_STATUS, `IDX_IRQ_MASK};
	logic [9:0]  txq[$];
	int          failures = 0;
	int          checks = 0;
	int          cycles = 0;
	int          edges = 0;
	// mode 0 transmit drives the shared data pin, otherwise the node does
	wire         rxdWire = rxdOeN ? nodeLine : rxdOut;

	serial_port_uart_regs DUT (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.txd(txd), .rxdIn(rxdWire), .rxdOut(rxdOut), .rxdOeN(rxdOeN), .irq(irq));
	serial_node_model node (.mclk(mclk), .txd(txd), .rxLine(nodeLine));

	always #2.5 mclk = ~mclk;
	// mode 0 data stands on the rising shift clock
	always @(posedge txd) begin
		if (!rxdOeN) begin
			sh <= {rxdOut, sh[7:1]};
			edges++;
		end
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	// ------------------------------
	// helpers
	// ------------------------------
	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// response ready is raised late so the answer has to stand
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		awaddr <= {i, 2'b00};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) bready <= 1'b1;
		end while (!(bvalid && bready));
		resp = bresp;
		bready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] i);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) rready <= 1'b1;
		end while (!(rvalid && rready));
		rv = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic sendTx(input logic [7:0] d, input logic [9:0] f);
		txq.push_back(f);
		wr(`IDX_DATA, {24'h0, d});
		while (node.got.size() == 0) @(posedge mclk);
		chk(node.got.pop_front() & (node.nb == 9 ? 10'h3ff : 10'h1ff), txq.pop_front());
	endtask
	function automatic logic hit(input logic [7:0] a);
		return (((a ^ own) & mask) == 8'h0) || ((a & (own | mask)) == (own | mask));
	endfunction

	// ------------------------------
	// sequence
	// ------------------------------
	initial begin
		void'($urandom(32'h4a50));
		// bit 0 set so the second address misses both matches
		own = 8'($urandom) | 8'h01;
		mask = 8'($urandom) | 8'h01;
		b = 8'($urandom);
		node.per = `RST_DIV;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		foreach (regs[k]) begin
			rd(regs[k]);
			chk(rv, (k == 4) ? {`RST_DIV, 16'h0} : 32'h0);
		end
		rd(8'hff);
		chk(resp, `RESP_SLVERR);
		wr(8'hff, 32'h1);
		chk(resp, `RESP_SLVERR);
		wr(`IDX_OWN_ADDR, own);
		wr(`IDX_ADDR_MASK, mask);
		rd(`IDX_OWN_ADDR);
		chk(rv, own);
		rd(`IDX_ADDR_MASK);
		chk(rv, mask);
		wr(`IDX_CONTROL, 32'h50);
		sendTx(b, {2'b01, b});
		rd(`IDX_CONTROL);
		chk(rv[1], 1'b1);
		wr(`IDX_IRQ_MASK, 32'h2);
		wr(`IDX_CONTROL, 32'h50);
		node.sendFrame(b ^ 8'h5a, 1'b1);
		rd(`IDX_DATA);
		chk(rv, b ^ 8'h5a);
		rd(`IDX_CONTROL);
		chk(rv[0], 1'b1);
		chk(irq, 1'b1);
		wr(`IDX_IRQ_STATUS, 32'h2);
		chk(irq, 1'b0);
		wr(`IDX_CONTROL, 32'h40);
		node.sendFrame(9'h0a5, 1'b1);
		rd(`IDX_CONTROL);
		chk(rv[0], 1'b0);
		node.nb = 9;
		wr(`IDX_CONTROL, 32'hd0);
		sendTx(~b, {2'b10, ~b});
		for (int n = 1; n >= 0; n--) begin
			wr(`IDX_CONTROL, 32'hdc - 4 * n);
			node.sendFrame({n[0], b}, 1'b1);
			rd(`IDX_CONTROL);
			chk(rv[2], n[0]);
		end
		adr = '{own, own ^ (mask & (~mask + 8'h01)), 8'hff, own};
		foreach (adr[k]) begin
			wr(`IDX_CONTROL, 32'hf0);
			node.sendFrame({k != 3, adr[k]}, 1'b1);
			rd(`IDX_CONTROL);
			chk(rv[0], (k != 3) && hit(adr[k]));
		end
		node.nb = 8;
		wr(`IDX_CONTROL, 32'h70);
		node.sendFrame({1'b0, adr[1]}, 1'b1);
		rd(`IDX_CONTROL);
		chk(rv[0], 1'b1);
		node.per = `DIV_MODE2;
		node.nb = 9;
		wr(`IDX_CONTROL, 32'h88);
		sendTx(b, {2'b11, b});
		node.per = `RST_DIV;
		node.nb = 8;
		wr(`IDX_CONTROL, 32'h50);
		node.sendFrame(9'h033, 1'b0);
		wr(`IDX_CONFIG, {`RST_DIV, 16'h1});
		rd(`IDX_CONTROL);
		chk(rv[7], 1'b1);
		node.sendFrame(9'h0cc, 1'b1);
		rd(`IDX_CONTROL);
		chk(rv[7], 1'b1);
		wr(`IDX_CONTROL, 32'h50);
		rd(`IDX_CONTROL);
		chk(rv[7], 1'b0);
		// mode 0 at double speed must finish well inside the window
		wr(`IDX_CONFIG, {`RST_DIV, 16'h3});
		wr(`IDX_CONTROL, 32'h00);
		wr(`IDX_DATA, {24'h0, b});
		repeat (60) @(posedge mclk);
		chk(sh, b);
		chk(edges, 8);
		rd(`IDX_CONTROL);
		chk(rv[1], 1'b1);
		report_and_stop();
	end
endmodule // serial_port_uart_regs_tb
